// ==== design/digital_input_conditioning_router.sv ====
// digital input conditioning and routing: per-input inversion, forcing and special-function
// gating, then 36 selectors build the digital input summary word.
// assumes the fieldbus slave hands over object accesses as single-cycle index/subindex strobes
// and that all pins are already synchronous to i_clock.
//
// Operation
// - special function follows its enable bit
// - enable bits 16 to 31 do nothing
// - bit0 negative limit, bit1 positive, bit2 home
// - invert bit 1 turns high into 0
// - inversion skips clock and direction inputs
// - force enable replaces level by software value
// - forced value taken from same bit position
// - raw word shows untouched input levels
// - threshold bit 0 is 5 V, 1 is 24 V
// - control bit n belongs to input n+1
// - 36 selectors, selector k drives bit k-1
// - 8-bit code picks each summary source
// - code 00 gives 0, 80 gives 1
// - codes 01-10 inputs, 81-90 inverted inputs
// - codes 41-46 hall and encoder, C1-C6 inverted
// - codes 47-50 usb, ethernet, dip; C7-D0 inverted
`timescale 1ns/1ns
module digital_input_conditioning_router
   import input_router_pkg::*;
#(
   parameter int              N_PHYS       = 16,
   parameter int              N_ROUTES     = 36,
   // inputs acting as clock and direction, exempt from inversion
   parameter logic [15:0]     CLKDIR_MASK  = 16'h0000
) (
   // clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   // input pins and status lines
   input  wire logic [N_PHYS-1:0]     i_in,
   input  wire logic [2:0]            i_hall,
   input  wire logic [2:0]            i_encoder,
   input  wire logic                  i_usb_power,
   input  wire logic                  i_eth_active,
   input  wire logic [7:0]            i_dip,
   // object access from the fieldbus master
   input  wire logic                  i_od_wr,
   input  wire logic                  i_od_rd,
   input  wire logic [15:0]           i_od_index,
   input  wire logic [7:0]            i_od_subindex,
   input  wire logic [31:0]           i_od_wdata,
   output logic [31:0]                o_od_rdata,
   output logic                       o_od_ack,
   output logic                       o_od_error,
   // conditioned results
   output logic [N_ROUTES-1:0]        o_digital_input_summary,
   output logic                       o_neg_limit,
   output logic                       o_pos_limit,
   output logic                       o_home,
   output logic [N_PHYS-1:0]          o_threshold_24v
);
   typedef struct packed {
      logic [31:0]               special_function_gate;
      logic [31:0]               input_polarity_invert;
      logic [31:0]               input_override_enable;
      logic [31:0]               input_override_value;
      logic [31:0]               input_unmodified_levels;
      logic [31:0]               input_threshold_select;
      logic [31:0]               input_differential_select;
      logic [31:0]               input_routing_gate;
      logic [N_ROUTES-1:0][7:0]  summary_bit_source_select;
      logic [N_ROUTES-1:0]       summary;
      logic                      neg_limit;
      logic                      pos_limit;
      logic                      home;
      logic [31:0]               rdata;
      logic                      ack;
      logic                      error;
   } state_type;

   state_type                 state_reg;
   state_type                 state_next;
   logic [N_PHYS-1:0]         inverted;
   logic [N_PHYS-1:0]         conditioned;
   logic [MISC_SOURCES-1:0]   misc;
   logic [N_ROUTES-1:0]       routed;
   logic                      ctrl_hit;
   logic                      route_hit;

   // inversion first so that a forced value is taken literally, never re-inverted
   assign inverted    = i_in ^ (state_reg.input_polarity_invert[N_PHYS-1:0]
                                & ~CLKDIR_MASK[N_PHYS-1:0]);
   assign conditioned = (inverted & ~state_reg.input_override_enable[N_PHYS-1:0])
                      | (state_reg.input_override_value[N_PHYS-1:0]
                         & state_reg.input_override_enable[N_PHYS-1:0]);
   assign misc        = {i_dip, i_eth_active, i_usb_power, i_encoder, i_hall};
   assign ctrl_hit    = (i_od_index == INDEX_INPUT_CTRL);
   assign route_hit   = (i_od_index == INDEX_INPUT_ROUTE);

   for (genvar k = 0; k < N_ROUTES; k++) begin : g_route
      route_source_mux #(
         .N_PHYS (N_PHYS)
      ) u_mux (
         .i_code (state_reg.summary_bit_source_select[k]),
         .i_phys (conditioned),
         .i_misc (misc),
         .o_bit  (routed[k])
      );
   end

   always_comb begin
      state_next       = state_reg;
      state_next.ack   = i_od_wr | i_od_rd;
      state_next.error = 1'b0;
      state_next.rdata = WORD_RESET;
      state_next.input_unmodified_levels = WORD_RESET;
      state_next.input_unmodified_levels[N_PHYS-1:0] = i_in;
      state_next.summary   = routed;
      // bits 16..31 of the gate are stored for readback only
      state_next.neg_limit = state_reg.special_function_gate[SF_NEG_LIMIT_BIT]
                           & conditioned[SF_NEG_LIMIT_BIT];
      state_next.pos_limit = state_reg.special_function_gate[SF_POS_LIMIT_BIT]
                           & conditioned[SF_POS_LIMIT_BIT];
      state_next.home      = state_reg.special_function_gate[SF_HOME_BIT]
                           & conditioned[SF_HOME_BIT];
      if (i_od_wr) begin
         if (ctrl_hit) begin
            case (i_od_subindex)
               SUB_SPECIAL_GATE: state_next.special_function_gate     = i_od_wdata;
               SUB_INVERT:       state_next.input_polarity_invert     = i_od_wdata;
               SUB_OVERRIDE_EN:  state_next.input_override_enable     = i_od_wdata;
               SUB_OVERRIDE_VAL: state_next.input_override_value      = i_od_wdata;
               SUB_UNMODIFIED:   state_next.error                     = 1'b0;
               SUB_THRESHOLD:    state_next.input_threshold_select    = i_od_wdata;
               SUB_DIFFERENTIAL: state_next.input_differential_select = i_od_wdata;
               SUB_ROUTING_GATE: state_next.input_routing_gate        = i_od_wdata;
               default:          state_next.error                     = 1'b1;
            endcase
         end else if (route_hit) begin
            state_next.error = 1'b1;
            for (int k = 0; k < N_ROUTES; k++) begin
               if (i_od_subindex == 8'(k + 1)) begin
                  state_next.summary_bit_source_select[k] = i_od_wdata[7:0];
                  state_next.error = 1'b0;
               end
            end
         end else begin
            state_next.error = 1'b1;
         end
      end else if (i_od_rd) begin
         if (ctrl_hit) begin
            case (i_od_subindex)
               SUB_ENTRY_COUNT:  state_next.rdata = {24'h00_0000, CTRL_COUNT_RESET};
               SUB_SPECIAL_GATE: state_next.rdata = state_reg.special_function_gate;
               SUB_INVERT:       state_next.rdata = state_reg.input_polarity_invert;
               SUB_OVERRIDE_EN:  state_next.rdata = state_reg.input_override_enable;
               SUB_OVERRIDE_VAL: state_next.rdata = state_reg.input_override_value;
               SUB_UNMODIFIED:   state_next.rdata = state_reg.input_unmodified_levels;
               SUB_THRESHOLD:    state_next.rdata = state_reg.input_threshold_select;
               SUB_DIFFERENTIAL: state_next.rdata = state_reg.input_differential_select;
               SUB_ROUTING_GATE: state_next.rdata = state_reg.input_routing_gate;
               default:          state_next.error = 1'b1;
            endcase
         end else if (route_hit) begin
            if (i_od_subindex == SUB_ENTRY_COUNT) begin
               state_next.rdata = {24'h00_0000, ROUTE_COUNT_RESET};
            end else begin
               state_next.error = 1'b1;
               for (int k = 0; k < N_ROUTES; k++) begin
                  if (i_od_subindex == 8'(k + 1)) begin
                     state_next.rdata = {24'h00_0000, state_reg.summary_bit_source_select[k]};
                     state_next.error = 1'b0;
                  end
               end
            end
         end else begin
            state_next.error = 1'b1;
         end
      end
      if (i_rst) begin
         state_next.special_function_gate     = WORD_RESET;
         state_next.input_polarity_invert     = WORD_RESET;
         state_next.input_override_enable     = WORD_RESET;
         state_next.input_override_value      = WORD_RESET;
         state_next.input_unmodified_levels   = WORD_RESET;
         state_next.input_threshold_select    = WORD_RESET;
         state_next.input_differential_select = WORD_RESET;
         state_next.input_routing_gate        = WORD_RESET;
         state_next.summary_bit_source_select = {N_ROUTES{SELECT_RESET}};
         state_next.summary   = '0;
         state_next.neg_limit = 1'b0;
         state_next.pos_limit = 1'b0;
         state_next.home      = 1'b0;
         state_next.rdata     = WORD_RESET;
         state_next.ack       = 1'b0;
         state_next.error     = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      state_reg <= state_next;
   end

   assign o_od_rdata              = state_reg.rdata;
   assign o_od_ack                = state_reg.ack;
   assign o_od_error              = state_reg.error;
   assign o_digital_input_summary = state_reg.summary;
   assign o_neg_limit             = state_reg.neg_limit;
   assign o_pos_limit             = state_reg.pos_limit;
   assign o_home                  = state_reg.home;
   assign o_threshold_24v         = state_reg.input_threshold_select[N_PHYS-1:0];

   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_threshold_write;
      i_od_wr && ctrl_hit && (i_od_subindex == SUB_THRESHOLD);
   endsequence

   sequence s_gate_write_upper_only;
      i_od_wr && ctrl_hit && (i_od_subindex == SUB_SPECIAL_GATE) && (i_od_wdata[15:0] == 16'h0000);
   endsequence

   logic [6:0] sel0_base;
   assign sel0_base = state_reg.summary_bit_source_select[0][6:0];

   a_neg_limit_gate: assert property (
      o_neg_limit == $past(state_reg.special_function_gate[SF_NEG_LIMIT_BIT] && conditioned[SF_NEG_LIMIT_BIT]))
      else $error("negative limit does not follow its gate and level");
   a_home_gate: assert property (
      o_home |-> $past(state_reg.special_function_gate[SF_HOME_BIT] && conditioned[SF_HOME_BIT]))
      else $error("home raised without enable and level");
   a_upper_gate_ignored: assert property (
      s_gate_write_upper_only ##1 1'b1 |=> !o_neg_limit && !o_pos_limit && !o_home)
      else $error("upper enable bits produced a special function");
   a_polarity_invert: assert property (
      ((conditioned ^ (i_in ^ state_reg.input_polarity_invert[N_PHYS-1:0]))
       & ~state_reg.input_override_enable[N_PHYS-1:0] & ~CLKDIR_MASK[N_PHYS-1:0]) == '0)
      else $error("input polarity wrong");
   a_clkdir_no_invert: assert property (
      ((conditioned ^ i_in) & ~state_reg.input_override_enable[N_PHYS-1:0] & CLKDIR_MASK[N_PHYS-1:0]) == '0)
      else $error("clock or direction input was inverted");
   a_override_value: assert property (
      ((conditioned ^ state_reg.input_override_value[N_PHYS-1:0])
       & state_reg.input_override_enable[N_PHYS-1:0]) == '0)
      else $error("forced input not taken from override value");
   a_raw_levels: assert property (
      ##1 state_reg.input_unmodified_levels[N_PHYS-1:0] == $past(i_in))
      else $error("raw word does not show input levels");
   a_threshold_write: assert property (
      s_threshold_write |=> o_threshold_24v == $past(i_od_wdata[N_PHYS-1:0]))
      else $error("threshold select not applied");
   a_constant_one: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h80) |-> o_digital_input_summary[0])
      else $error("code 80 did not give 1");
   a_phys_route: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h81)
      |-> o_digital_input_summary[0] == !$past(conditioned[0]))
      else $error("inverted input 1 routed wrongly");
   a_hall_route: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h41) |-> o_digital_input_summary[0] == $past(i_hall[0]))
      else $error("hall u routed wrongly");
   a_dip_route: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'hD0) |-> o_digital_input_summary[0] == !$past(i_dip[7]))
      else $error("inverted dip 8 routed wrongly");
   a_unlisted_zero: assert property (
      $past((sel0_base > 7'h10 && sel0_base < 7'h41) || sel0_base > 7'h50) |-> !o_digital_input_summary[0])
      else $error("unlisted code did not give 0");

   // answer timing of the object access port: exactly one cycle, error only with ack
   sequence s_strobe;
      i_od_wr || i_od_rd;
   endsequence

   sequence s_sel0_write;
      i_od_wr && route_hit && (i_od_subindex == 8'h01);
   endsequence

   a_ack_after_strobe: assert property (
      s_strobe |=> o_od_ack)
      else $error("no ack one cycle after a strobe");
   a_ack_only_strobed: assert property (
      o_od_ack |-> $past(i_od_wr || i_od_rd))
      else $error("ack without a strobe one cycle before");
   a_error_with_ack: assert property (
      o_od_error |-> o_od_ack)
      else $error("error flag without ack");
   a_error_rdata_zero: assert property (
      o_od_error |-> o_od_rdata == 32'h0000_0000)
      else $error("read data not zero on error");
   a_selector_write: assert property (
      s_sel0_write |=> state_reg.summary_bit_source_select[0] == $past(i_od_wdata[7:0]))
      else $error("selector 1 write not stored");
   a_last_selector: assert property (
      $past(state_reg.summary_bit_source_select[N_ROUTES-1] == 8'h80) |-> o_digital_input_summary[N_ROUTES-1])
      else $error("last selector does not drive the top summary bit");
   a_gate_low_bits: assert property (
      $past(state_reg.special_function_gate[2:0] == 3'b000) |-> !o_neg_limit && !o_pos_limit && !o_home)
      else $error("special function active with its enable clear");
   a_unforced_route: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h01 && !state_reg.input_override_enable[0]
            && !CLKDIR_MASK[0])
      |-> o_digital_input_summary[0] == $past(i_in[0] ^ state_reg.input_polarity_invert[0]))
      else $error("input 1 not routed with its own invert bit");
   a_forced_route: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h01 && state_reg.input_override_enable[0])
      |-> o_digital_input_summary[0] == $past(state_reg.input_override_value[0]))
      else $error("forced input 1 not taken from override bit 0");
   a_force_after_invert: assert property (
      $past(state_reg.summary_bit_source_select[0] == 8'h01 && state_reg.input_override_enable[0]
            && state_reg.input_polarity_invert[0])
      |-> o_digital_input_summary[0] == $past(state_reg.input_override_value[0]))
      else $error("forced value was inverted again");
endmodule : digital_input_conditioning_router

// ==== design/input_router_pkg.sv ====
// constants for the digital input conditioning and routing block.
// object-dictionary addressing is index plus subindex, as the fieldbus master sees it.
package input_router_pkg;
   // object indices
   localparam logic [15:0] INDEX_INPUT_CTRL   = 16'h3240;
   localparam logic [15:0] INDEX_INPUT_ROUTE  = 16'h3242;
   // subindices of the input control object
   localparam logic [7:0]  SUB_ENTRY_COUNT    = 8'h00;
   localparam logic [7:0]  SUB_SPECIAL_GATE   = 8'h01;
   localparam logic [7:0]  SUB_INVERT         = 8'h02;
   localparam logic [7:0]  SUB_OVERRIDE_EN    = 8'h03;
   localparam logic [7:0]  SUB_OVERRIDE_VAL   = 8'h04;
   localparam logic [7:0]  SUB_UNMODIFIED     = 8'h05;
   localparam logic [7:0]  SUB_THRESHOLD      = 8'h06;
   localparam logic [7:0]  SUB_DIFFERENTIAL   = 8'h07;
   localparam logic [7:0]  SUB_ROUTING_GATE   = 8'h08;
   // reset values
   localparam logic [7:0]  CTRL_COUNT_RESET   = 8'h08;
   localparam logic [7:0]  ROUTE_COUNT_RESET  = 8'h24;
   localparam logic [31:0] WORD_RESET         = 32'h0000_0000;
   localparam logic [7:0]  SELECT_RESET       = 8'h00;
   // special-function bit positions
   localparam int          SF_NEG_LIMIT_BIT   = 0;
   localparam int          SF_POS_LIMIT_BIT   = 1;
   localparam int          SF_HOME_BIT        = 2;
   // routing code layout: bit 7 inverts, bits 6..0 pick the source
   localparam int          CODE_INVERT_BIT    = 7;
   localparam logic [6:0]  CODE_CONSTANT      = 7'h00;
   localparam logic [6:0]  CODE_PHYS_FIRST    = 7'h01;
   localparam logic [6:0]  CODE_MISC_FIRST    = 7'h41;
   localparam int          MISC_SOURCES       = 16;
endpackage : input_router_pkg

// ==== design/route_source_mux.sv ====
// one routing selector: turns an 8-bit source code into one summary bit.
// assumes conditioned physical inputs and the misc lines arrive already sampled.
`timescale 1ns/1ns
module route_source_mux
   import input_router_pkg::*;
#(
   parameter int N_PHYS = 16
) (
   // source code
   input  wire logic [7:0]              i_code,
   // candidate sources
   input  wire logic [N_PHYS-1:0]       i_phys,
   input  wire logic [MISC_SOURCES-1:0] i_misc,
   // selected bit
   output logic                         o_bit
);
   logic [6:0] base;
   logic       hit;
   logic       value;

   assign base = i_code[6:0];

   always_comb begin
      hit   = 1'b0;
      value = 1'b0;
      if (base == CODE_CONSTANT) begin
         hit = 1'b1;
      end
      for (int i = 0; i < N_PHYS; i++) begin
         if (base == 7'(int'(CODE_PHYS_FIRST) + i)) begin
            hit   = 1'b1;
            value = i_phys[i];
         end
      end
      for (int j = 0; j < MISC_SOURCES; j++) begin
         if (base == 7'(int'(CODE_MISC_FIRST) + j)) begin
            hit   = 1'b1;
            value = i_misc[j];
         end
      end
      // an unlisted code gives 0 even with the invert bit set
      o_bit = hit & (value ^ i_code[CODE_INVERT_BIT]);
   end
endmodule : route_source_mux

// ==== dv/field_side_model.sv ====
// far side of the input block: switch, hall, encoder and dip levels plus the fieldbus master.
// assumes the block takes a strobe on a rising edge and answers one cycle later.
`timescale 1ns/1ns
module field_side_model (
   // clock
   input  wire logic        i_clock,
   // object answers
   input  wire logic [31:0] i_od_rdata,
   input  wire logic        i_od_ack,
   input  wire logic        i_od_error,
   // pin levels
   output logic [15:0]      o_in,
   output logic [2:0]       o_hall,
   output logic [2:0]       o_encoder,
   output logic             o_usb_power,
   output logic             o_eth_active,
   output logic [7:0]       o_dip,
   // object requests
   output logic             o_od_wr,
   output logic             o_od_rd,
   output logic [15:0]      o_od_index,
   output logic [7:0]       o_od_subindex,
   output logic [31:0]      o_od_wdata
);
   initial begin
      {o_in, o_hall, o_encoder, o_usb_power, o_eth_active, o_dip} = '0;
      {o_od_wr, o_od_rd, o_od_index, o_od_subindex, o_od_wdata} = '0;
   end

   task automatic set_pins(input logic [15:0] p, input logic [15:0] m);
      @(posedge i_clock);
      o_in <= p;
      {o_dip, o_eth_active, o_usb_power, o_encoder, o_hall} <= m;
   endtask : set_pins

   // one object access; address and data are scrambled once released so nothing stale is seen
   task automatic od_access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                            input logic [31:0] wd, output logic [31:0] rd, output logic ack,
                            output logic err);
      @(posedge i_clock);
      o_od_wr       <= wr;
      o_od_rd       <= ~wr;
      o_od_index    <= idx;
      o_od_subindex <= sub;
      o_od_wdata    <= wd;
      @(posedge i_clock);
      o_od_wr       <= 1'b0;
      o_od_rd       <= 1'b0;
      o_od_index    <= ~idx;
      o_od_subindex <= ~sub;
      o_od_wdata    <= ~wd;
      @(negedge i_clock);
      rd  = i_od_rdata;
      ack = i_od_ack;
      err = i_od_error;
   endtask : od_access
endmodule : field_side_model

// ==== dv/digital_input_conditioning_router_test.sv ====
// self-checking bench for the input conditioning and routing block.
// assumes the far-side model supplies pin levels and object accesses.
`timescale 1ns/1ns
module digital_input_conditioning_router_test;
   import input_router_pkg::*;
   localparam logic [15:0] CLKDIR = 16'h8000;
   logic clock, i_rst, od_wr, od_rd, ack_w, err_w, usb, eth, neg_l, pos_l, home, ack, err;
   logic [15:0] pins, od_index, th;
   logic [2:0]  hall, enc;
   logic [7:0]  dip, od_sub;
   logic [31:0] od_wdata, rdata, rd;
   logic [35:0] summary;
   int          failures;
   int          n_tests;

   digital_input_conditioning_router #(.N_PHYS(16), .N_ROUTES(36), .CLKDIR_MASK(CLKDIR)) u_digital_input_conditioning_router (
      .i_clock(clock), .i_rst(i_rst), .i_in(pins), .i_hall(hall), .i_encoder(enc), .i_usb_power(usb),
      .i_eth_active(eth), .i_dip(dip), .i_od_wr(od_wr), .i_od_rd(od_rd), .i_od_index(od_index),
      .i_od_subindex(od_sub), .i_od_wdata(od_wdata), .o_od_rdata(rdata), .o_od_ack(ack_w),
      .o_od_error(err_w), .o_digital_input_summary(summary), .o_neg_limit(neg_l), .o_pos_limit(pos_l),
      .o_home(home), .o_threshold_24v(th));
   field_side_model u_field_side_model (
      .i_clock(clock), .i_od_rdata(rdata), .i_od_ack(ack_w), .i_od_error(err_w), .o_in(pins),
      .o_hall(hall), .o_encoder(enc), .o_usb_power(usb), .o_eth_active(eth), .o_dip(dip),
      .o_od_wr(od_wr), .o_od_rd(od_rd), .o_od_index(od_index), .o_od_subindex(od_sub),
      .o_od_wdata(od_wdata));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic test_done();
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic exp_err);
      u_field_side_model.od_access(wr, idx, sub, wd, rd, ack, err);
      chk({ack, err}, {1'b1, exp_err});
      if (exp_err) chk(rd, 0);
   endtask : acc

   task automatic settle();
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask : settle

   function automatic logic route_exp(input logic [7:0] code, input logic [15:0] c, input logic [15:0] m);
      logic [6:0] s;
      s = code[6:0];
      if (s == 7'h00) return code[7];
      if (s >= 7'h01 && s <= 7'h10) return c[s - 7'h01] ^ code[7];
      if (s >= 7'h41 && s <= 7'h50) return m[s - 7'h41] ^ code[7];
      return 1'b0;
   endfunction : route_exp

   task automatic check_reset_values();
      chk({summary, neg_l, pos_l, home, th}, 0);
      for (int s = 0; s <= 8; s++) begin
         acc(1'b0, INDEX_INPUT_CTRL, 8'(s), 32'h0, 1'b0);
         chk(rd, (s == 0) ? 32'h0000_0008 : 32'h0000_0000);
      end
      acc(1'b0, INDEX_INPUT_ROUTE, 8'h00, 32'h0, 1'b0);
      chk(rd, 32'h0000_0024);
      acc(1'b0, INDEX_INPUT_ROUTE, 8'h24, 32'h0, 1'b0);
      chk(rd, 32'h0000_0000);
   endtask : check_reset_values

   task automatic check_refusals();
      acc(1'b1, INDEX_INPUT_CTRL, SUB_ENTRY_COUNT, 32'h0000_00FF, 1'b1);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_UNMODIFIED, 32'hFFFF_FFFF, 1'b0);
      acc(1'b0, INDEX_INPUT_CTRL, SUB_UNMODIFIED, 32'h0, 1'b0);
      chk(rd, 32'h0000_0000);
      acc(1'b1, INDEX_INPUT_ROUTE, 8'h00, 32'h0000_00FF, 1'b1);
      acc(1'b0, INDEX_INPUT_ROUTE, 8'h25, 32'h0, 1'b1);
      acc(1'b0, 16'h3241, 8'h01, 32'h0, 1'b1);
      acc(1'b0, INDEX_INPUT_CTRL, SUB_ENTRY_COUNT, 32'h0, 1'b0);
      chk(rd, 32'h0000_0008);
   endtask : check_refusals

   // every code on selector 1, with two complementary pin patterns; no conditioning is set yet
   task automatic check_route_codes();
      logic [15:0] p, m;
      for (int pi = 0; pi < 2; pi++) begin
         p = pi ? 16'h5A3C : 16'hA5C3;
         m = pi ? 16'hA5AA : 16'h5A55;
         u_field_side_model.set_pins(p, m);
         for (int code = 0; code < 256; code++) begin
            acc(1'b1, INDEX_INPUT_ROUTE, 8'h01, 32'(code), 1'b0);
            settle();
            chk(summary[0], route_exp(8'(code), p, m));
         end
      end
   endtask : check_route_codes

   task automatic check_conditioning();
      logic [15:0] inv, fe, fv, p, m, c;
      logic [7:0]  codes [36];
      logic [35:0] exp;
      inv = 16'h8F0F;
      fe  = 16'h0303;
      fv  = 16'h0201;
      for (int k = 0; k < 36; k++) begin
         codes[k] = (k < 16) ? 8'(k + 1) : (k < 32) ? 8'(8'h41 + k - 16) : 8'h00;
      end
      codes[32] = 8'hA0;
      codes[34] = 8'h90;
      codes[35] = 8'h80;
      for (int k = 0; k < 36; k++) acc(1'b1, INDEX_INPUT_ROUTE, 8'(k + 1), {24'h0, codes[k]}, 1'b0);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_INVERT, {16'h0, inv}, 1'b0);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_OVERRIDE_EN, {16'h0, fe}, 1'b0);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_OVERRIDE_VAL, {16'h0, fv}, 1'b0);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_SPECIAL_GATE, 32'hFFFF_0005, 1'b0);
      acc(1'b1, INDEX_INPUT_CTRL, SUB_THRESHOLD, 32'h0000_1234, 1'b0);
      for (int pi = 0; pi < 2; pi++) begin
         p = pi ? 16'h5A3C : 16'hA5C3;
         m = pi ? 16'hA5AA : 16'h5A55;
         u_field_side_model.set_pins(p, m);
         settle();
         c = (fe & fv) | (~fe & (p ^ (inv & ~CLKDIR)));
         for (int k = 0; k < 36; k++) exp[k] = route_exp(codes[k], c, m);
         chk(summary, exp);
         chk({neg_l, pos_l, home}, {c[0], 1'b0, c[2]});
         chk(th, 16'h1234);
         acc(1'b0, INDEX_INPUT_CTRL, SUB_UNMODIFIED, 32'h0, 1'b0);
         chk(rd, {16'h0, p});
      end
      // the controller clears every special-function enable, so limits and home all go low
      acc(1'b1, INDEX_INPUT_CTRL, SUB_SPECIAL_GATE, 32'h0000_0000, 1'b0);
      settle();
      chk({neg_l, pos_l, home}, 3'b000);
   endtask : check_conditioning

   // reset in mid-run, with levels back to 0, must bring back every reset value
   task automatic check_mid_reset();
      u_field_side_model.set_pins(16'h0000, 16'h0000);
      @(posedge clock);
      i_rst <= 1'b1;
      repeat (2) @(posedge clock);
      i_rst <= 1'b0;
      @(negedge clock);
      check_reset_values();
   endtask : check_mid_reset

   initial begin
      #(50 * 100000);
      failures++;
      test_done();
   end

   initial begin
      failures = 0;
      n_tests  = 0;
      i_rst    = 1'b1;
      repeat (4) @(posedge clock);
      i_rst <= 1'b0;
      @(negedge clock);
      check_reset_values();
      check_refusals();
      check_route_codes();
      check_conditioning();
      check_mid_reset();
      test_done();
   end
endmodule : digital_input_conditioning_router_test
